// ==== six_two_pulse_modulator.sv ====
/*
 * Six plus two pulse width modulator with one or two channels and a
 * small register port for duty values and pin control.
 * Assumes: strobes one cycle long, read data wanted the cycle after the
 * read strobe, all inputs synchronous to i_sys_clk.
 */
`include "six_two_pwm_cfg.svh"
`default_nettype none

module six_two_pulse_modulator #(
    parameter int unsigned CHANNELS = 2         // One or two outputs
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [3:0] i_addr,      // Register index
    input  wire logic [7:0] i_wdata,     // Write data
    input  wire logic       i_wr,        // Write strobe
    input  wire logic       i_rd,        // Read strobe
    output logic      [7:0] o_rdata,     // Read data, one cycle later
    output logic      [1:0] o_pin_out,   // Pin drive level
    output logic      [1:0] o_pin_oe_n   // Low while the pin is driven
);

    // -----------------------------------------------------------------
    // Request bundle
    // -----------------------------------------------------------------
    six_two_pwm_pkg::reg_req_t req;      // Grouped bus request
    assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

    // Register address decode, used by both write and read paths
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // -----------------------------------------------------------------
    // Phase counter
    // -----------------------------------------------------------------
    // Free counter on the raw clock; wraps every 256 clocks
    logic [7:0] phase_ff;                // Position within cycle
    wire  logic [7:0] nxt_phase = phase_ff + 8'h01;
    // Last clock of a cycle: duty copies load here
    wire  logic cyc_start = (phase_ff == 8'hFF);

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            phase_ff <= 8'h00;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // -----------------------------------------------------------------
    // Software registers
    // -----------------------------------------------------------------
    logic [7:0] duty_value_ch0_ff;       // Channel 0 duty
    logic [7:0] duty_value_ch1_ff;       // Channel 1 duty
    logic [1:0] port_data_ff;            // Pin on/off per channel
    logic [1:0] port_direction_register_ff; // One: input, zero: output

    wire logic wr_d0  = req.wr & hit(req.addr, `PWM_OFS_DUTY_CH0);
    wire logic wr_d1  = req.wr & hit(req.addr, `PWM_OFS_DUTY_CH1)
                        & (CHANNELS > 1);
    wire logic wr_pd  = req.wr & hit(req.addr, `PWM_OFS_PORT_DATA);
    wire logic wr_dir = req.wr & hit(req.addr, `PWM_OFS_PORT_DIR);

    // Writes accepted in any cycle; the channel resamples at cycle end
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            duty_value_ch0_ff <= `PWM_DUTY_RST;
            duty_value_ch1_ff <= `PWM_DUTY_RST;
        end else begin
            if (wr_d0) begin
                duty_value_ch0_ff <= req.wdata;
            end
            if (wr_d1) begin
                duty_value_ch1_ff <= req.wdata;
            end
        end
    end

    // Pin control registers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            port_data_ff               <= `PWM_PORT_DATA_RST;
            port_direction_register_ff <= `PWM_PORT_DIR_RST;
        end else begin
            if (wr_pd) begin
                port_data_ff <= req.wdata[1:0];
            end
            if (wr_dir) begin
                port_direction_register_ff <= req.wdata[1:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // Channels
    // -----------------------------------------------------------------
    wire logic [7:0] duty_arr [2];        // Per-channel duty sources
    assign duty_arr[0] = duty_value_ch0_ff;
    assign duty_arr[1] = duty_value_ch1_ff;

    six_two_pwm_pkg::duty_split_t active [2]; // Latched copies
    logic [1:0] wave;                         // Raw waveforms

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            if (g < CHANNELS) begin : g_on
                six_two_pwm_channel six_two_pwm_channel_inst (
                    .i_sys_clk   (i_sys_clk),
                    .i_sys_rst   (i_sys_rst),
                    .i_duty      (duty_arr[g]),
                    .i_cyc_start (cyc_start),
                    .i_phase     (phase_ff),
                    .o_active    (active[g]),
                    .o_wave      (wave[g])
                );
            end else begin : g_off
                // Absent channel stays quiet
                assign active[g] = '0;
                assign wave[g]   = 1'b0;
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Pin stage
    // -----------------------------------------------------------------
    // Waveform is already registered; gate by port data bit. The gate adds
    // a flop so the pin lags the phase counter by two clocks.
    wire logic [1:0] nxt_pin_out = wave & port_data_ff;
    wire logic [1:0] nxt_pin_oe_n = port_direction_register_ff;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_pin_out  <= 2'h0;
            o_pin_oe_n <= `PWM_PORT_DIR_RST;
        end else begin
            o_pin_out  <= nxt_pin_out;
            o_pin_oe_n <= nxt_pin_oe_n;
        end
    end

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------
    // Status: active base of ch0 and the current sub-cycle index, phase_ff[7:6]
    wire logic [7:0] status_word = {active[0].base_high_count,
                                    phase_ff[7:6]};
    wire logic [7:0] nxt_rdata =
        !req.rd                                 ? 8'h00 :
        hit(req.addr, `PWM_OFS_DUTY_CH0)        ? duty_value_ch0_ff :
        hit(req.addr, `PWM_OFS_DUTY_CH1)        ? duty_value_ch1_ff :
        hit(req.addr, `PWM_OFS_PORT_DATA)       ? {6'h00, port_data_ff} :
        hit(req.addr, `PWM_OFS_PORT_DIR)        ? {6'h00, port_direction_register_ff} :
        hit(req.addr, `PWM_OFS_STATUS)          ? status_word :
                                                  8'h00;   // Unmapped reads zero

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= nxt_rdata;
        end
    end

endmodule : six_two_pulse_modulator

`default_nettype wire

// ==== six_two_pwm_cfg.svh ====
/*
 * Register map and field positions of the six plus two pulse modulator.
 * Assumes: included by bare name; contents are `define macros only.
 */
`ifndef SIX_TWO_PWM_CFG_SVH
`define SIX_TWO_PWM_CFG_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define PWM_ADDR_W          4
`define PWM_OFS_DUTY_CH0    4'h0
`define PWM_OFS_DUTY_CH1    4'h1
`define PWM_OFS_PORT_DATA   4'h2
`define PWM_OFS_PORT_DIR    4'h3
`define PWM_OFS_STATUS      4'h4

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define PWM_DUTY_RST        8'h00
`define PWM_PORT_DATA_RST   2'h0
`define PWM_PORT_DIR_RST    2'h3

// -----------------------------------------------------------------
// Field positions and timing
// -----------------------------------------------------------------
`define PWM_BASE_MSB        7
`define PWM_BASE_LSB        2
`define PWM_EXT_MSB         1
`define PWM_EXT_LSB         0
`define PWM_SUB_CLKS        64
`define PWM_CYCLE_CLKS      256

`endif

// ==== six_two_pwm_pkg.sv ====
/*
 * Types shared by the modulator files.
 * Assumes: compiled before any module that names it.
 */
`default_nettype none

package six_two_pwm_pkg;

    // Duty value split into its two groups
    typedef struct packed {
        logic [5:0] base_high_count;  // Upper six bits
        logic [1:0] extension_count;  // Lower two bits
    } duty_split_t;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : six_two_pwm_pkg

`default_nettype wire

// ==== six_two_pwm_channel.sv ====
/*
 * One modulator channel: keeps a latched duty copy and compares it to the
 * shared phase counter.
 * Assumes: phase counter shared by all channels, single clock.
 */
`include "six_two_pwm_cfg.svh"
`default_nettype none

module six_two_pwm_channel (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_sys_rst,
    input  wire logic [7:0]                 i_duty,     // Software copy
    input  wire logic                       i_cyc_start,// Last clock of cycle
    input  wire logic [7:0]                 i_phase,    // Position in cycle
    output var  six_two_pwm_pkg::duty_split_t o_active, // Latched copy
    output logic                            o_wave      // Raw waveform
);

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    wire logic [1:0] sub_idx  = i_phase[7:6];   // Sub-cycle index
    wire logic [5:0] sub_pos  = i_phase[5:0];   // Clock within sub-cycle
    wire logic       extend   = (sub_idx < o_active.extension_count);
    // Seven bits so base 63 plus one reaches 64 (all high)
    wire logic [6:0] high_len = {1'b0, o_active.base_high_count}
                                + {6'h00, extend};
    wire logic       nxt_wave = ({1'b0, sub_pos} < high_len);

    // -----------------------------------------------------------------
    // Latch duty only at cycle boundary, never mid-cycle
    // -----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_active <= `PWM_DUTY_RST;
        end else if (i_cyc_start) begin
            o_active <= i_duty;
        end
    end

    // Waveform registered
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_wave <= 1'b0;
        end else begin
            o_wave <= nxt_wave;
        end
    end

endmodule : six_two_pwm_channel

`default_nettype wire

// ==== six_two_pwm_asserts.sv ====
/* Port checker for the six plus two modulator.
   Assumes: bound into the top module; one clock, synchronous reset. */
`default_nettype none
module six_two_pwm_asserts #(
    parameter int unsigned CHANNELS = 2  // Same count as the design
) (
    input wire logic       i_sys_clk,
    input wire logic       i_sys_rst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [1:0] o_pin_out,
    input wire logic [1:0] o_pin_oe_n
);
    // ------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------
    logic [7:0]       d0_ff, d1_ff;              // Duty copies
    logic [1:0]       pd_ff, dir_ff;             // Pin data, direction
    logic [7:0]       cnt_ff;                    // Clocks since release
    wire  logic [7:0] pos = cnt_ff - 8'h02;      // Phase shown on the pin
    // Mirror writes; the pin lags the count by two clocks
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            {d0_ff, d1_ff, pd_ff, dir_ff, cnt_ff} <= {16'h0000, 2'h0, 2'h3, 8'h00};
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
            if (i_wr && i_addr == 4'h0) d0_ff <= i_wdata;
            if (i_wr && i_addr == 4'h1 && CHANNELS > 1) d1_ff <= i_wdata;
            if (i_wr && i_addr == 4'h2) pd_ff <= i_wdata[1:0];
            if (i_wr && i_addr == 4'h3) dir_ff <= i_wdata[1:0];
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // Read strobe at one index
    sequence rd_of(logic [3:0] a);
        i_rd && i_addr == a;
    endsequence
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not cleared");
    duty0_back_a: assert property (rd_of(4'h0) |=> o_rdata == $past(d0_ff))
        else $error("channel 0 duty read wrong");
    duty1_back_a: assert property (rd_of(4'h1) |=> o_rdata == $past(d1_ff))
        else $error("channel 1 duty read wrong");
    port_back_a: assert property (rd_of(4'h2) |=> o_rdata[1:0] == $past(pd_ff))
        else $error("port data read wrong");
    dir_back_a: assert property (rd_of(4'h3) |=> o_rdata[1:0] == $past(dir_ff))
        else $error("direction read wrong");
    unmapped_rd_a: assert property (i_rd && i_addr > 4'h4 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    // The enable flop lags the direction register by one clock
    oe_dir_a: assert property (o_pin_oe_n == $past(dir_ff))
        else $error("enable differs from direction");
    status_idx_a: assert property (rd_of(4'h4) |=> o_rdata[1:0] == $past(cnt_ff[7:6]))
        else $error("status sub-cycle index wrong");
    pin_off_a: assert property ((o_pin_out & ~(pd_ff | $past(pd_ff) | $past(pd_ff, 2))) == 2'b00)
        else $error("pin high while switched off");
    rise_start_a: assert property ($rose(o_pin_out[0]) && pd_ff[0] && $past(pd_ff[0], 3) |-> pos[5:0] == 6'h00)
        else $error("pin rose inside a sub-cycle");
endmodule : six_two_pwm_asserts
bind six_two_pulse_modulator six_two_pwm_asserts #(.CHANNELS(CHANNELS)) six_two_pwm_asserts_inst (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n));
`default_nettype wire

// ==== six_two_load_model.sv ====
/* Averaging load on one modulator pin.
   Assumes: pin sampled on the system clock; the reader takes differences. */
`default_nettype none
module six_two_load_model (
    input  wire logic       i_clk,   // System clock
    input  wire logic       i_pin,   // Pulse train
    output logic      [8:0] o_level  // Running sum of high clocks
);
    initial o_level = 9'h000;
    // Integrates the pulses; wraps harmlessly over one window
    // Plain clocked process: the start value comes from the initial block
    always @(posedge i_clk) begin
        o_level <= o_level + {8'h00, i_pin};
    end
endmodule : six_two_load_model
`default_nettype wire

// ==== six_two_pulse_modulator_tb_top.sv ====
/* Self-checking bench for the six plus two modulator.
   Assumes: design, checker and load model compiled before it. */
`default_nettype none
module six_two_pulse_modulator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic                      i_sys_clk = 1'b0;
    logic                      i_sys_rst = 1'b1;
    six_two_pwm_pkg::reg_req_t req = '0;          // Register port request
    logic [7:0]                o_rdata;
    logic [1:0]                o_pin_out, o_pin_oe_n;
    logic [8:0]                level;             // Load model sum
    logic [7:0]                cnt = 8'h00;       // Clocks since release
    wire  logic [7:0]          pos = cnt - 8'h02; // Phase shown on the pin
    int                        fail_count = 0, total_checks = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) cnt <= i_sys_rst ? 8'h00 : cnt + 8'h01;
    six_two_pulse_modulator #(.CHANNELS(2)) six_two_pulse_modulator_inst (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(req.addr),
        .i_wdata(req.wdata), .i_wr(req.wr), .i_rd(req.rd), .o_rdata(o_rdata),
        .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n));
    // Channel 1 drives the averaging load
    six_two_load_model six_two_load_model_inst (
        .i_clk(i_sys_clk), .i_pin(o_pin_out[1]), .o_level(level));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_sys_clk);
        req.wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [8:0] exp);
        @(posedge i_sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_sys_clk);
        req.rd <= 1'b0;
        #1 check({1'b0, o_rdata}, exp);
    endtask : rd
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, unmapped index, direction as software sets it
    task automatic t_regs;
        rd(4'h0, 9'h000);
        rd(4'h1, 9'h000);
        rd(4'h2, 9'h000);
        rd(4'h3, 9'h003);
        rd(4'hF, 9'h000);
        wr(4'h3, 8'h00);
        wr(4'h1, 8'h3C);
        rd(4'h1, 9'h03C);
        check({7'h00, o_pin_oe_n}, 9'h000);
    endtask : t_regs
    // One full cycle, pin 0 high clocks summed per sub-cycle; a mid-cycle write must not leak in
    task automatic t_cycle(input logic [7:0] v0, input logic [7:0] v1,
                           input logic [7:0] nv, input logic [1:0] pd);
        logic [8:0] acc [4];
        logic [8:0] lv;
        acc = '{4{9'h000}};
        wr(4'h0, v0);
        wr(4'h1, v1);
        wr(4'h2, {6'h00, pd});
        repeat (2) begin
            do @(negedge i_sys_clk); while (pos != 8'h00);
        end
        lv = level;
        for (int n = 0; n < 256; n++) begin
            acc[n / 64] += {8'h00, o_pin_out[0]};
            @(posedge i_sys_clk);
            req <= '{wr: (n == 99), rd: 1'b0, addr: 4'h0, wdata: nv};
            @(negedge i_sys_clk);
        end
        for (int i = 0; i < 4; i++) begin
            check(acc[i], pd[0] ? {3'h0, v0[7:2]} + {8'h00, (i < v0[1:0])} : 9'h000);
        end
        check(level - lv, pd[1] ? {1'b0, v1} : 9'h000);
    endtask : t_cycle
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        t_regs();
        t_cycle(8'h00, 8'hFE, 8'hFF, 2'b11);
        t_cycle(8'h05, 8'h01, 8'h80, 2'b11);
        t_cycle(8'hFE, 8'h02, 8'h00, 2'b11);
        t_cycle(8'hFF, 8'h83, 8'h13, 2'b11);
        t_cycle(8'h83, 8'h00, 8'hFF, 2'b11);
        t_cycle(8'hFF, 8'h40, 8'h00, 2'b10);
        print_verdict();
    end
    // Six cycles take well under a third of this
    initial begin
        #1ms;
        fail_count++;
        print_verdict();
    end
endmodule : six_two_pulse_modulator_tb_top
`default_nettype wire
